/* File: smbus_i2c_slave_interface.sv */
// Two-wire serial slave giving a bus master access to a byte-wide register map.
`timescale 1ns/1ps

module smbus_i2c_slave_interface #(
  parameter int unsigned LOW_TMO_CYC = smbus_slave_pkg::LOW_TMO_CYC_DEF
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  input  wire logic                     timeout_en_i,
  input  wire logic                     deep_sleep_i,
  input  wire logic [7:0]               rd_data_i,
  output logic                          sda_o,
  output logic                          sda_oe_o,
  output logic [7:0]                    rd_addr_o,
  output smbus_slave_pkg::wr_req_s      wr_o,
  output logic                          wr_en_o
);
  import smbus_slave_pkg::*;

  bus_lines_s   line_m;
  bus_lines_s   line_s;
  bus_lines_s   line_d;
  slave_state_e state;
  logic [3:0]   cnt;
  logic [7:0]   shreg;
  logic         rw;
  logic         first_byte;
  logic         in_txn;
  logic         rep_start;
  logic         ptr_loaded;
  logic         data_moved;
  logic         master_ack;
  logic [7:0]   saved_ptr;
  logic [19:0]  low_cnt;
  logic [12:0]  idle_cnt;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_ev;
  logic         stop_ev;
  logic         low_hit;
  logic         idle_hit;
  logic         abort;
  logic         quiet;
  logic         byte_full;
  logic         ev_ptr_load;
  logic         ev_wr;
  logic         ev_tx_next;
  logic         ev_restore;
  logic         addr_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Both lines come from pins, so each passes two flops before any logic.

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      line_m <= '{scl: 1'b1, sda: 1'b1};
      line_s <= '{scl: 1'b1, sda: 1'b1};
      line_d <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      line_m <= '{scl: scl_i, sda: sda_i};
      line_s <= line_m;
      line_d <= line_s;
    end
  end

  assign scl_rise  = line_s.scl & ~line_d.scl;
  assign scl_fall  = ~line_s.scl & line_d.scl;
  assign start_ev  = line_s.scl & line_d.scl & line_d.sda & ~line_s.sda;
  assign stop_ev   = line_s.scl & line_d.scl & ~line_d.sda & line_s.sda;
  assign abort     = low_hit | idle_hit;
  assign quiet     = ~abort & ~start_ev & ~stop_ev;
  assign byte_full = (cnt == BYTE_BITS);

  // A read opened by a fresh start is a receive byte, refused in deep sleep.
  assign addr_ok = (shreg[7:1] == DEV_ADDR)
                && !(shreg[0] && deep_sleep_i && !rep_start);

  assign ev_ptr_load = quiet && (state == ST_RX) && scl_fall && byte_full && first_byte;
  assign ev_wr       = quiet && (state == ST_RX) && scl_fall && byte_full && !first_byte;
  assign ev_tx_next  = quiet && (state == ST_TX) && scl_fall && byte_full;
  assign ev_restore  = ~abort && stop_ev && in_txn && deep_sleep_i && ptr_loaded && !data_moved;

  ////////////////////////////////////////////////////////////////////////////////
  // Timeouts; both are gated by the one enable, which resets low.

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_cnt <= 20'h00000;
    end else if (!timeout_en_i || line_s.scl) begin
      low_cnt <= 20'h00000;
    end else if (low_cnt != 20'(LOW_TMO_CYC)) begin
      low_cnt <= low_cnt + 20'h00001;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_cnt <= 13'h0000;
    end else if (!timeout_en_i || !line_s.scl || !line_s.sda) begin
      idle_cnt <= 13'h0000;
    end else if (idle_cnt <= 13'(IDLE_TMO_CYC)) begin
      idle_cnt <= idle_cnt + 13'h0001;
    end
  end

  assign low_hit  = (low_cnt == 20'(LOW_TMO_CYC));
  // Gated by the live lines, so that a start after a long idle is not swallowed.
  assign idle_hit = (idle_cnt > 13'(IDLE_TMO_CYC)) && line_s.scl && line_s.sda;

  ////////////////////////////////////////////////////////////////////////////////
  // Protocol engine. The data line is only ever changed after a sampled clock
  // fall, so output hold is at least the synchroniser delay; the clock line is
  // never driven at all, so stretching by the master is waited out until an enabled timeout expires.

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state      <= ST_IDLE;
      cnt        <= CNT_RST;
      shreg      <= 8'h00;
      rw         <= 1'b0;
      first_byte <= 1'b0;
      in_txn     <= 1'b0;
      rep_start  <= 1'b0;
      ptr_loaded <= 1'b0;
      data_moved <= 1'b0;
      master_ack <= 1'b0;
      sda_o      <= 1'b0;
      sda_oe_o   <= 1'b0;
    end else if (abort) begin
      state    <= ST_IDLE;
      in_txn   <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (start_ev) begin
      state     <= ST_ADDR;
      cnt       <= CNT_RST;
      sda_oe_o  <= 1'b0;
      in_txn    <= 1'b1;
      rep_start <= in_txn;
      if (!in_txn) begin
        ptr_loaded <= 1'b0;
        data_moved <= 1'b0;
      end
    end else if (stop_ev) begin
      state    <= ST_IDLE;
      in_txn   <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_RX: begin
          if (scl_rise && !byte_full) begin
            shreg <= {shreg[6:0], line_s.sda};
            cnt   <= cnt + 4'h1;
          end else if (scl_fall && byte_full) begin
            if (state == ST_ADDR) begin
              if (addr_ok) begin
                sda_oe_o <= 1'b1;
                rw       <= shreg[0];
                state    <= ST_ADDR_ACK;
                if (shreg[0]) begin
                  data_moved <= 1'b1;
                end
              end else begin
                state  <= ST_IDLE;
                in_txn <= 1'b0;
              end
            end else begin
              sda_oe_o <= 1'b1;
              state    <= ST_RX_ACK;
              if (first_byte) begin
                first_byte <= 1'b0;
                ptr_loaded <= 1'b1;
              end else begin
                data_moved <= 1'b1;
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt <= CNT_RST;
            if (rw) begin
              sda_oe_o <= ~rd_data_i[7];
              shreg    <= {rd_data_i[6:0], 1'b0};
              state    <= ST_TX;
            end else begin
              sda_oe_o   <= 1'b0;
              first_byte <= 1'b1;
              state      <= ST_RX;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            cnt      <= CNT_RST;
            state    <= ST_RX;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (scl_fall) begin
            if (byte_full) begin
              sda_oe_o <= 1'b0;
              state    <= ST_TX_ACK;
            end else begin
              sda_oe_o <= ~shreg[7];
              shreg    <= {shreg[6:0], 1'b0};
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            master_ack <= ~line_s.sda;
          end else if (scl_fall) begin
            cnt <= CNT_RST;
            if (master_ack) begin
              sda_oe_o <= ~rd_data_i[7];
              shreg    <= {rd_data_i[6:0], 1'b0};
              state    <= ST_TX;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register pointer. A send byte in deep sleep is undone at its stop, since
  // only then is it known that no data followed the register address.

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_addr_o <= PTR_RST;
      saved_ptr <= PTR_RST;
    end else if (ev_ptr_load) begin
      saved_ptr <= rd_addr_o;
      rd_addr_o <= shreg;
    end else if (ev_wr || ev_tx_next) begin
      rd_addr_o <= rd_addr_o + 8'h01;
    end else if (ev_restore) begin
      rd_addr_o <= saved_ptr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write strobe toward the register map, one cycle per received data byte.

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_en_o <= 1'b0;
      wr_o    <= '{addr: PTR_RST, data: 8'h00};
    end else begin
      wr_en_o <= ev_wr;
      if (ev_wr) begin
        wr_o <= '{addr: rd_addr_o, data: shreg};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  a_start_to_addr: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (start_ev && !abort) |=> (state == ST_ADDR) && !sda_oe_o)
    else $error("start did not enter address phase");

  a_stop_to_idle: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (stop_ev && !start_ev) |=> (state == ST_IDLE) && !sda_oe_o)
    else $error("stop did not return to idle");

  a_drive_clk_low: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    $changed(sda_oe_o) |-> !line_d.scl)
    else $error("data line changed while clock high");

  a_addr_mismatch: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (quiet && state == ST_ADDR && scl_fall && byte_full && shreg[7:1] != DEV_ADDR)
      |=> !sda_oe_o && (state == ST_IDLE))
    else $error("foreign address was acknowledged");

  a_rx_ack_bit: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (quiet && state == ST_RX && scl_fall && byte_full) |=> sda_oe_o && !sda_o)
    else $error("received byte not acknowledged");

  a_ptr_wrap: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_en_o |-> (rd_addr_o == 8'(wr_o.addr + 8'h01)))
    else $error("pointer did not advance after write");

  a_wr_one_pulse: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    wr_en_o |=> !wr_en_o)
    else $error("write strobe longer than one cycle");

  a_tmo_disabled: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !timeout_en_i |=> !low_hit && !idle_hit)
    else $error("timeout fired while disabled");

  a_low_timeout: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (timeout_en_i && !line_s.scl && low_cnt == 20'(LOW_TMO_CYC - 1)) |=> ##1
      (state == ST_IDLE) && !sda_oe_o)
    else $error("clock-low timeout did not reset interface");

endmodule

/* File: smbus_slave_pkg.sv */
// Constants and carrier types shared by the two-wire slave interface.
package smbus_slave_pkg;

  // Fixed 7-bit target address 0101_000.
  localparam logic [6:0] DEV_ADDR = 7'h28;

  // Bits in one byte, counted on rising serial clock edges.
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Core clock rate.
  localparam int unsigned CLK_HZ = 20_000_000;

  // Clock-low timeout, in milliseconds, and its cycle count.
  localparam int unsigned LOW_TMO_MS = 30;
  localparam int unsigned LOW_TMO_CYC_DEF = (CLK_HZ / 1000) * LOW_TMO_MS;

  // Bus-idle timeout, in microseconds, and its cycle count.
  localparam int unsigned IDLE_TMO_US = 200;
  localparam int unsigned IDLE_TMO_CYC = (CLK_HZ / 1_000_000) * IDLE_TMO_US;

  // Reset values.
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;

  // Protocol states, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX       = 7'h08,
    ST_RX_ACK   = 7'h10,
    ST_TX       = 7'h20,
    ST_TX_ACK   = 7'h40
  } slave_state_e;

  // Sampled bus lines.
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_s;

  // One register write toward the register map.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } wr_req_s;

endpackage

/* File: smbus_host_model.sv */
// Behavioural bus master that drives the serial clock and data lines.
`timescale 1ns/1ps

module smbus_host_model (
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  int lo_extra = 0;
  int hi_extra = 0;

  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One bit is 4 core cycles low and 4 high, 400 ns, unless stretched.
  // Data changes one cycle after the fall so that it never moves while the clock is high.
  task automatic put_bit(input logic b, output logic seen);
    @(posedge core_clk_i);
    sda_low_o <= ~b;
    repeat (3 + lo_extra) @(posedge core_clk_i);
    scl_o <= 1'b1;
    repeat (4 + hi_extra) @(posedge core_clk_i);
    seen = sda_i;
    scl_o <= 1'b0;
  endtask

  task automatic start_cond();
    @(posedge core_clk_i);
    sda_low_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sda_low_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    scl_o <= 1'b0;
  endtask

  task automatic stop_cond();
    @(posedge core_clk_i);
    sda_low_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    sda_low_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask

  // Eight bits most significant first, then the ninth clock.
  task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx,
                      output logic ack_seen);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(ack_bit, ack_seen);
  endtask
endmodule

/* File: smbus_i2c_slave_interface_tb.sv */
// Self-checking testbench for the two-wire slave interface.
`timescale 1ns/1ps

module smbus_i2c_slave_interface_tb;
  import smbus_slave_pkg::*;
  localparam logic [7:0] WR_ADDR = {DEV_ADDR, 1'b0};
  localparam logic [7:0] RD_ADDR = {DEV_ADDR, 1'b1};

  logic       core_clk   = 1'b0;
  logic       nrst       = 1'b0;
  logic       timeout_en = 1'b0;
  logic       deep_sleep = 1'b0;
  logic       scl;
  logic       host_low;
  logic       sda_line;
  logic       sda_oe;
  logic       sda_out;
  logic       wr_en;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] rx;
  logic       ack;
  wr_req_s    wr;
  wr_req_s    wq[$];
  int         n_fail     = 0;
  int         num_checks = 0;
  int         cycles     = 0;

  always #25 core_clk = ~core_clk;
  // The line has a pull-up; the slave's pin shows its output value only while enabled.
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~host_low;
  assign rd_data  = rd_addr ^ 8'ha5;

  smbus_i2c_slave_interface #(.LOW_TMO_CYC(200)) i_smbus_i2c_slave_interface (
    .core_clk_i(core_clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda_line),
    .timeout_en_i(timeout_en), .deep_sleep_i(deep_sleep), .rd_data_i(rd_data),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .rd_addr_o(rd_addr), .wr_o(wr), .wr_en_o(wr_en));

  smbus_host_model i_smbus_host_model (
    .core_clk_i(core_clk), .sda_i(sda_line), .scl_o(scl), .sda_low_o(host_low));

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    if (wr_en === 1'b1) wq.push_back(wr);
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic exp_ack);
    i_smbus_host_model.xfer(b, 1'b1, rx, ack);
    check("ack", {15'h0, ack}, {15'h0, exp_ack});
  endtask

  task automatic recv(input logic nack, input logic [7:0] exp);
    i_smbus_host_model.xfer(8'hff, nack, rx, ack);
    check("read data", {8'h0, rx}, {8'h0, exp});
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_block_write();
    logic [15:0] exp [3] = '{16'hfe11, 16'hff22, 16'h0033};
    wq.delete();
    i_smbus_host_model.start_cond();
    send(WR_ADDR, 1'b0);
    send(8'hfe, 1'b0);
    for (int k = 0; k < 3; k++) send(exp[k][7:0], 1'b0);
    i_smbus_host_model.stop_cond();
    check("write count", 16'(wq.size()), 16'h3);
    for (int k = 0; k < wq.size() && k < 3; k++) check("write", wq[k], exp[k]);
    check("pointer", {8'h0, rd_addr}, 16'h1);
    $display("done block write");
  endtask

  task automatic t_bad_addr();
    logic [7:0] bad [3] = '{8'h52, 8'ha1, 8'h10};
    foreach (bad[k]) begin
      i_smbus_host_model.start_cond();
      send(bad[k], 1'b1);
      i_smbus_host_model.stop_cond();
    end
    check("pointer", {8'h0, rd_addr}, 16'h1);
    $display("done foreign address");
  endtask

  task automatic t_block_read();
    i_smbus_host_model.start_cond();
    send(WR_ADDR, 1'b0);
    send(8'h40, 1'b0);
    i_smbus_host_model.start_cond();
    send(RD_ADDR, 1'b0);
    recv(1'b0, 8'h40 ^ 8'ha5);
    recv(1'b1, 8'h41 ^ 8'ha5);
    i_smbus_host_model.stop_cond();
    check("pointer", {8'h0, rd_addr}, 16'h42);
    $display("done block read");
  endtask

  task automatic t_sleep();
    wq.delete();
    deep_sleep <= 1'b1;
    i_smbus_host_model.start_cond();
    send(RD_ADDR, 1'b1);
    i_smbus_host_model.stop_cond();
    i_smbus_host_model.start_cond();
    send(WR_ADDR, 1'b0);
    send(8'h77, 1'b0);
    i_smbus_host_model.stop_cond();
    check("pointer", {8'h0, rd_addr}, 16'h42);
    deep_sleep <= 1'b0;
    i_smbus_host_model.start_cond();
    send(WR_ADDR, 1'b0);
    send(8'h77, 1'b0);
    i_smbus_host_model.stop_cond();
    check("pointer", {8'h0, rd_addr}, 16'h77);
    check("write count", 16'(wq.size()), 16'h0);
    i_smbus_host_model.start_cond();
    send(RD_ADDR, 1'b0);
    recv(1'b1, 8'h77 ^ 8'ha5);
    i_smbus_host_model.stop_cond();
    $display("done deep sleep");
  endtask

  task automatic t_stop_abort();
    i_smbus_host_model.start_cond();
    i_smbus_host_model.put_bit(1'b0, ack);
    i_smbus_host_model.put_bit(1'b1, ack);
    i_smbus_host_model.stop_cond();
    i_smbus_host_model.start_cond();
    send(WR_ADDR, 1'b0);
    send(8'h05, 1'b0);
    i_smbus_host_model.stop_cond();
    check("pointer", {8'h0, rd_addr}, 16'h5);
    $display("done stop abort");
  endtask

  // Stretches the second address bit low or high; an abort leaves the address unacknowledged.
  task automatic tmo_case(input logic en, input int lo, input int hi, input logic exp_ack);
    timeout_en <= en;
    i_smbus_host_model.start_cond();
    i_smbus_host_model.put_bit(WR_ADDR[7], ack);
    i_smbus_host_model.lo_extra = lo;
    i_smbus_host_model.hi_extra = hi;
    i_smbus_host_model.put_bit(WR_ADDR[6], ack);
    i_smbus_host_model.lo_extra = 0;
    i_smbus_host_model.hi_extra = 0;
    for (int i = 5; i >= 0; i--) i_smbus_host_model.put_bit(WR_ADDR[i], ack);
    i_smbus_host_model.put_bit(1'b1, ack);
    check("timeout ack", {15'h0, ack}, {15'h0, exp_ack});
    i_smbus_host_model.stop_cond();
    $display("done timeout case");
  endtask

  // A long idle with the timeout on resets the interface but must not eat the next start.
  task automatic t_idle_start();
    timeout_en <= 1'b1;
    repeat (4100) @(posedge core_clk);
    i_smbus_host_model.start_cond();
    send(WR_ADDR, 1'b0);
    send(8'h0c, 1'b0);
    i_smbus_host_model.stop_cond();
    check("pointer", {8'h0, rd_addr}, 16'h0c);
    timeout_en <= 1'b0;
    $display("done idle start");
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    check("oe in reset", {15'h0, sda_oe}, 16'h0);
    check("pointer in reset", {8'h0, rd_addr}, 16'h0);
    check("write in reset", {15'h0, wr_en}, 16'h0);
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    t_block_write();
    t_bad_addr();
    t_block_read();
    t_sleep();
    t_stop_abort();
    tmo_case(1'b1, 300, 0, 1'b1);
    tmo_case(1'b0, 300, 0, 1'b0);
    tmo_case(1'b1, 0, 4200, 1'b1);
    tmo_case(1'b0, 0, 4200, 1'b0);
    t_idle_start();
    give_verdict();
  end
endmodule
